/* dctp_datapath.sv */
// Purpose: 8x8 forward/inverse cosine transform datapath, one sample per clock
// Assumes: upstream holds one sample per cycle; blocks of 64 marked by a start pulse
// Notes: transposition store has three banks so the fixed latency never collides
// Contract
// - 12-bit samples, 9-bit auxiliary, two's complement
// - Bit 0 is LSB, bit 11 sign
// - Nine-bit data uses upper bits, low three zero
// - Exact products; 16-bit intermediate, 9/12-bit output
// - Discarded bits round toward plus infinity
// - Overflow saturates to extreme of true sign
// - Clipping modes force negatives to zero
// - Auxiliary subtracted from input, same cycle
// - Forward input nine bits, difference saturated
// - Sum saturated, clipped, placed on bits 11-3
// - Plain and clip-only inverse modes without addition
// - Power-on contents undefined; first blocks unreliable
// - Forward transform for selects 000, 100
// - Forward input direct or from subtractor
// - Forward stage one: round 8, keep 16
// - Forward output: round 19, keep 12
// - Fixed 14-bit coefficients, one equals 4096
// - Forward coefficients from scaled cosine formula
// - Output eight times normalised transform
// - Inverse transform for selects 001, 101, 111
// - Inverse: 12-bit in, 16-bit middle, 9-bit out
// - Start latches select; next 63 cycles ignore start
// - Columns in, rows out, 128 cycles latency
// - Inverse matrix is forward matrix transposed
`timescale 1ns/100ps

package dctp_pkg;
  localparam int SMP_W = 12;
  localparam int AUX_W = 9;
  localparam int PIX_W = 9;
  localparam int OUT_W = 12;
  localparam int MID_W = 16;
  localparam int COEF_W = 14;
  localparam int ACC1_W = 29;
  localparam int ACC2_W = 33;
  localparam int LOW_W = SMP_W - AUX_W;
  localparam int N_PT = 8;
  localparam int BLK_LEN = 64;
  localparam int RND1_SH = 8;
  localparam int RND2_SH = 19;
  localparam int NBANK = 3;
  localparam int MEM_DEPTH = NBANK * BLK_LEN;
  localparam int FIFO_DEPTH = 4;
  localparam int LATENCY = 128;
  localparam int AUX_LEAD = 124;
  localparam int AUX_DLY = LATENCY - AUX_LEAD;
  localparam int SER_LAG = 9;
  localparam int STG2_DLY = LATENCY - BLK_LEN - SER_LAG - 2;
  localparam logic [5:0] LAST_IDX = 6'h3F;
  localparam logic [5:0] STG2_DLY_V = 6'(STG2_DLY);
  localparam logic [2:0] LAST_PT = 3'h7;
  localparam logic [1:0] LAST_BANK = 2'(NBANK - 1);
  localparam logic [2:0] SEL_DCT = 3'h0;
  localparam logic [2:0] SEL_DCT_SUB = 3'h4;
  localparam logic [2:0] SEL_IDCT = 3'h1;
  localparam logic [2:0] SEL_IDCT_CLIP = 3'h5;
  localparam logic [2:0] SEL_IDCT_ADD = 3'h7;
  localparam logic [13:0] COEF_ONE = 14'h1000;
  localparam logic [13:0] COEF_C1 = 14'h1631;
  localparam logic [13:0] COEF_C2 = 14'h14E8;
  localparam logic [13:0] COEF_C3 = 14'h12D0;
  localparam logic [13:0] COEF_C5 = 14'h0C92;
  localparam logic [13:0] COEF_C6 = 14'h08A9;
  localparam logic [13:0] COEF_C7 = 14'h046A;

  typedef enum logic [4:0] {
    MODE_DCT = 5'h01,
    MODE_DCT_SUB = 5'h02,
    MODE_IDCT = 5'h04,
    MODE_IDCT_CLIP = 5'h08,
    MODE_IDCT_ADD = 5'h10
  } dctp_mode_e;

  typedef struct packed {
    dctp_mode_e mode;
    logic [1:0] bank;
  } dctp_tag_s;

  // Forward coefficient k,m; the inverse uses coef(m,k)
  function automatic logic signed [13:0] coef(input logic [2:0] k, input logic [2:0] m);
    logic [6:0] prod;
    logic [4:0] p;
    logic [3:0] q;
    logic [13:0] mag;
    prod = {3'h0, m, 1'b1} * {4'h0, k};
    p = prod[4:0];
    q = p[3] ? 4'(5'h10 - {1'b0, p[3:0]}) : p[3:0];
    case (q)
      4'h1: mag = COEF_C1;
      4'h2: mag = COEF_C2;
      4'h3: mag = COEF_C3;
      4'h5: mag = COEF_C5;
      4'h6: mag = COEF_C6;
      4'h7: mag = COEF_C7;
      default: mag = COEF_ONE;
    endcase
    if (k == 3'h0) begin
      coef = COEF_ONE;
    end else if (p > 5'h08 && p < 5'h18) begin
      coef = -$signed(mag);
    end else begin
      coef = $signed(mag);
    end
  endfunction : coef

  function automatic logic signed [33:0] round_up(input logic signed [32:0] v, input int sh);
    logic signed [33:0] w;
    w = 34'(v);
    // A bare bit would make the sum unsigned and the shift logical
    round_up = (w >>> sh) + (v[sh - 1] ? 34'sh1 : 34'sh0);
  endfunction : round_up

  function automatic logic signed [15:0] sat(input logic signed [33:0] v, input int w);
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    hi = (34'sh1 <<< (w - 1)) - 34'sh1;
    lo = -hi - 34'sh1;
    if (v > hi) begin
      sat = 16'(hi);
    end else if (v < lo) begin
      sat = 16'(lo);
    end else begin
      sat = 16'(v);
    end
  endfunction : sat

  // Unsupported selects fall back to the plain inverse
  function automatic dctp_mode_e decode(input logic [2:0] sel);
    case (sel)
      SEL_DCT: decode = MODE_DCT;
      SEL_DCT_SUB: decode = MODE_DCT_SUB;
      SEL_IDCT_CLIP: decode = MODE_IDCT_CLIP;
      SEL_IDCT_ADD: decode = MODE_IDCT_ADD;
      default: decode = MODE_IDCT;
    endcase
  endfunction : decode

  function automatic logic is_fwd(input dctp_mode_e mode);
    is_fwd = (mode == MODE_DCT) || (mode == MODE_DCT_SUB);
  endfunction : is_fwd
endpackage : dctp_pkg

module dctp_datapath (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_GO,
  input wire logic [2:0] I_SEL,
  input wire logic [11:0] I_DIN,
  input wire logic [8:0] I_AUX_OPERAND_IN,
  input wire logic I_DOUT_READY,
  output logic [11:0] O_DOUT,
  output logic O_DOUT_VALID,
  output logic O_PUSH_READY
);
  logic act1_reg;
  logic [5:0] cnt1_reg;
  dctp_pkg::dctp_tag_s tag1_reg;
  logic go_take;
  logic samp_take;
  logic [5:0] samp_idx;
  logic [1:0] bank_nxt;
  dctp_pkg::dctp_tag_s cur_tag;
  logic signed [8:0] din9;
  logic signed [9:0] dif;
  logic signed [8:0] fwd9;
  logic signed [11:0] x_in;
  logic xv_reg;
  logic [5:0] xi_reg;
  logic signed [11:0] x_reg;
  dctp_pkg::dctp_tag_s x_tag_reg;
  logic x_last;
  logic signed [15:0] col_hold [dctp_pkg::N_PT];
  logic wr_act_reg;
  logic [2:0] wr_k_reg;
  logic [2:0] wr_col_reg;
  logic [1:0] wr_bank_reg;
  logic signed [15:0] tmem [dctp_pkg::MEM_DEPTH];
  logic pend_reg;
  logic [5:0] dly_reg;
  dctp_pkg::dctp_tag_s pend_tag_reg;
  logic act2_reg;
  logic [5:0] cnt2_reg;
  dctp_pkg::dctp_tag_s tag2_reg;
  logic signed [15:0] rd_reg;
  logic rv_reg;
  logic [5:0] ri_reg;
  dctp_pkg::dctp_tag_s rtag_reg;
  logic r_last;
  logic signed [11:0] row_hold [dctp_pkg::N_PT];
  logic ser_act_reg;
  logic [2:0] ser_i_reg;
  dctp_pkg::dctp_tag_s otag_reg;
  logic signed [8:0] aux_d_reg [dctp_pkg::AUX_DLY];
  logic signed [8:0] v9;
  logic signed [8:0] sum9;
  logic [11:0] out_word;

  // Start is only honoured outside a block in progress
  assign go_take = I_GO && (!act1_reg || cnt1_reg == dctp_pkg::LAST_IDX);
  assign samp_take = go_take || (act1_reg && cnt1_reg != dctp_pkg::LAST_IDX);
  assign samp_idx = go_take ? 6'h00 : 6'(cnt1_reg + 6'h01);
  assign bank_nxt = (tag1_reg.bank == dctp_pkg::LAST_BANK) ? 2'h0 : 2'(tag1_reg.bank + 2'h1);

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      act1_reg <= 1'b0;
      cnt1_reg <= 6'h00;
      tag1_reg <= '{mode: dctp_pkg::MODE_DCT, bank: 2'h0};
    end else if (go_take) begin
      act1_reg <= 1'b1;
      cnt1_reg <= 6'h00;
      tag1_reg <= '{mode: dctp_pkg::decode(I_SEL), bank: bank_nxt};
    end else if (act1_reg) begin
      cnt1_reg <= 6'(cnt1_reg + 6'h01);
      if (cnt1_reg == dctp_pkg::LAST_IDX) begin
        act1_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    cur_tag = go_take ? dctp_pkg::dctp_tag_s'{mode: dctp_pkg::decode(I_SEL), bank: bank_nxt} : tag1_reg;
    din9 = $signed(I_DIN[11:dctp_pkg::LOW_W]);
    dif = 10'(din9) - 10'($signed(I_AUX_OPERAND_IN));
    if (cur_tag.mode == dctp_pkg::MODE_DCT_SUB) begin
      fwd9 = 9'(dctp_pkg::sat(34'(dif), dctp_pkg::PIX_W));
    end else begin
      fwd9 = din9;
    end
    if (dctp_pkg::is_fwd(cur_tag.mode)) begin
      x_in = 12'(fwd9);
    end else begin
      x_in = $signed(I_DIN);
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      xv_reg <= 1'b0;
      xi_reg <= 6'h00;
      x_reg <= 12'sh000;
      x_tag_reg <= '{mode: dctp_pkg::MODE_DCT, bank: 2'h0};
    end else begin
      xv_reg <= samp_take;
      xi_reg <= samp_idx;
      x_reg <= x_in;
      x_tag_reg <= cur_tag;
    end
  end

  assign x_last = xv_reg && xi_reg[2:0] == dctp_pkg::LAST_PT;

  // Column pass: every input feeds all eight partial sums
  for (genvar k = 0; k < dctp_pkg::N_PT; k++) begin : g_col
    logic signed [13:0] c;
    logic signed [28:0] acc_reg;
    logic signed [28:0] acc_next;
    assign c = dctp_pkg::is_fwd(x_tag_reg.mode) ? dctp_pkg::coef(3'(k), xi_reg[2:0])
                                                : dctp_pkg::coef(xi_reg[2:0], 3'(k));
    assign acc_next = (xi_reg[2:0] == 3'h0 ? 29'sh0 : acc_reg) + 29'(x_reg) * 29'(c);
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        acc_reg <= 29'sh0;
        col_hold[k] <= 16'sh0;
      end else if (xv_reg) begin
        acc_reg <= acc_next;
        if (x_last) begin
          col_hold[k] <= dctp_pkg::sat(dctp_pkg::round_up(33'(acc_next), dctp_pkg::RND1_SH),
                                       dctp_pkg::MID_W);
        end
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      wr_act_reg <= 1'b0;
      wr_k_reg <= 3'h0;
      wr_col_reg <= 3'h0;
      wr_bank_reg <= 2'h0;
    end else if (x_last) begin
      wr_act_reg <= 1'b1;
      wr_k_reg <= 3'h0;
      wr_col_reg <= xi_reg[5:3];
      wr_bank_reg <= x_tag_reg.bank;
    end else if (wr_act_reg) begin
      wr_k_reg <= 3'(wr_k_reg + 3'h1);
      if (wr_k_reg == dctp_pkg::LAST_PT) begin
        wr_act_reg <= 1'b0;
      end
    end
  end

  // Store is never cleared, so blocks after power-up may read stale words
  always_ff @(posedge I_REF_CLK) begin
    if (wr_act_reg) begin
      tmem[{wr_bank_reg, wr_k_reg, wr_col_reg}] <= col_hold[wr_k_reg];
    end
  end

  // Row pass launches a fixed delay after the last column lands
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      pend_reg <= 1'b0;
      dly_reg <= 6'h00;
      pend_tag_reg <= '{mode: dctp_pkg::MODE_DCT, bank: 2'h0};
    end else if (x_last && xi_reg == dctp_pkg::LAST_IDX) begin
      pend_reg <= 1'b1;
      dly_reg <= dctp_pkg::STG2_DLY_V;
      pend_tag_reg <= x_tag_reg;
    end else if (pend_reg) begin
      if (dly_reg == 6'h00) begin
        pend_reg <= 1'b0;
      end else begin
        dly_reg <= 6'(dly_reg - 6'h01);
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      act2_reg <= 1'b0;
      cnt2_reg <= 6'h00;
      tag2_reg <= '{mode: dctp_pkg::MODE_DCT, bank: 2'h0};
    end else if (pend_reg && dly_reg == 6'h00) begin
      act2_reg <= 1'b1;
      cnt2_reg <= 6'h00;
      tag2_reg <= pend_tag_reg;
    end else if (act2_reg) begin
      cnt2_reg <= 6'(cnt2_reg + 6'h01);
      if (cnt2_reg == dctp_pkg::LAST_IDX) begin
        act2_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    rd_reg <= tmem[{tag2_reg.bank, cnt2_reg}];
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      rv_reg <= 1'b0;
      ri_reg <= 6'h00;
      rtag_reg <= '{mode: dctp_pkg::MODE_DCT, bank: 2'h0};
    end else begin
      rv_reg <= act2_reg;
      ri_reg <= cnt2_reg;
      rtag_reg <= tag2_reg;
    end
  end

  assign r_last = rv_reg && ri_reg[2:0] == dctp_pkg::LAST_PT;

  // Row pass: full 33-bit sums, no loss until the final selector
  for (genvar k = 0; k < dctp_pkg::N_PT; k++) begin : g_row
    logic signed [13:0] c;
    logic signed [32:0] acc_reg;
    logic signed [32:0] acc_next;
    logic signed [33:0] rnd;
    assign c = dctp_pkg::is_fwd(rtag_reg.mode) ? dctp_pkg::coef(3'(k), ri_reg[2:0])
                                               : dctp_pkg::coef(ri_reg[2:0], 3'(k));
    assign acc_next = (ri_reg[2:0] == 3'h0 ? 33'sh0 : acc_reg) + 33'(rd_reg) * 33'(c);
    assign rnd = dctp_pkg::round_up(acc_next, dctp_pkg::RND2_SH);
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        acc_reg <= 33'sh0;
        row_hold[k] <= 12'sh000;
      end else if (rv_reg) begin
        acc_reg <= acc_next;
        if (r_last && dctp_pkg::is_fwd(rtag_reg.mode)) begin
          row_hold[k] <= 12'(dctp_pkg::sat(rnd, dctp_pkg::OUT_W));
        end else if (r_last) begin
          row_hold[k] <= 12'(dctp_pkg::sat(rnd, dctp_pkg::PIX_W));
        end
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ser_act_reg <= 1'b0;
      ser_i_reg <= 3'h0;
      otag_reg <= '{mode: dctp_pkg::MODE_DCT, bank: 2'h0};
    end else if (r_last) begin
      ser_act_reg <= 1'b1;
      ser_i_reg <= 3'h0;
      otag_reg <= rtag_reg;
    end else if (ser_act_reg) begin
      ser_i_reg <= 3'(ser_i_reg + 3'h1);
      if (ser_i_reg == dctp_pkg::LAST_PT) begin
        ser_act_reg <= 1'b0;
      end
    end
  end

  // Operand arrives ahead of its output by the delay depth
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < dctp_pkg::AUX_DLY; i++) begin
        aux_d_reg[i] <= 9'sh000;
      end
    end else begin
      aux_d_reg[0] <= $signed(I_AUX_OPERAND_IN);
      for (int i = 1; i < dctp_pkg::AUX_DLY; i++) begin
        aux_d_reg[i] <= aux_d_reg[i - 1];
      end
    end
  end

  always_comb begin
    v9 = 9'(row_hold[ser_i_reg]);
    sum9 = 9'(dctp_pkg::sat(34'(v9) + 34'(aux_d_reg[dctp_pkg::AUX_DLY - 1]), dctp_pkg::PIX_W));
    case (otag_reg.mode)
      dctp_pkg::MODE_DCT, dctp_pkg::MODE_DCT_SUB: begin
        out_word = row_hold[ser_i_reg];
      end
      dctp_pkg::MODE_IDCT: begin
        out_word = {v9, 3'h0};
      end
      dctp_pkg::MODE_IDCT_CLIP: begin
        out_word = v9[8] ? 12'h000 : {v9, 3'h0};
      end
      dctp_pkg::MODE_IDCT_ADD: begin
        out_word = sum9[8] ? 12'h000 : {sum9, 3'h0};
      end
      default: begin
        out_word = 12'h000;
      end
    endcase
  end

  // No stall is possible upstream; a full queue drops the word
  dctp_fifo #(
    .WIDTH(dctp_pkg::OUT_W),
    .DEPTH(dctp_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_in_valid(ser_act_reg),
    .i_in_data(out_word),
    .o_in_ready(O_PUSH_READY),
    .o_out_valid(O_DOUT_VALID),
    .o_out_data(O_DOUT),
    .i_out_ready(I_DOUT_READY)
  );
endmodule : dctp_datapath

/* dctp_fifo.sv */
// Purpose: small shift-register queue on the output stream
// Assumes: single clock, asynchronous active-high reset
// Notes: head and ready are flops so the top drives its pins from registers
`timescale 1ns/100ps

module dctp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  logic [WIDTH-1:0] data_reg [DEPTH];
  logic [WIDTH-1:0] data_next [DEPTH];
  logic [DEPTH-1:0] vld_reg;
  logic [DEPTH-1:0] vld_next;
  logic ready_reg;
  logic pop;
  logic push;
  logic placed;

  assign pop = vld_reg[0] && i_out_ready;
  assign push = i_in_valid && ready_reg;

  always_comb begin
    vld_next = vld_reg;
    data_next = data_reg;
    placed = 1'b0;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        data_next[i] = data_reg[i + 1];
        vld_next[i] = vld_reg[i + 1];
      end
      vld_next[DEPTH - 1] = 1'b0;
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!vld_next[i] && !placed) begin
          data_next[i] = i_in_data;
          vld_next[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vld_reg <= '0;
      ready_reg <= 1'b1;
      for (int i = 0; i < DEPTH; i++) begin
        data_reg[i] <= '0;
      end
    end else begin
      vld_reg <= vld_next;
      ready_reg <= !vld_next[DEPTH - 1];
      data_reg <= data_next;
    end
  end

  assign o_in_ready = ready_reg;
  assign o_out_valid = vld_reg[0];
  assign o_out_data = data_reg[0];
endmodule : dctp_fifo

/* dctp_datapath_properties.sv */
// Purpose: port checker for the transform datapath
// Assumes: one clock, asynchronous active-high reset
// Notes: intake counter mirrors the block-start acceptance
`timescale 1ns/100ps

module dctp_checker (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_GO,
  input wire logic [2:0] I_SEL,
  input wire logic [11:0] I_DIN,
  input wire logic [8:0] I_AUX_OPERAND_IN,
  input wire logic I_DOUT_READY,
  input wire logic [11:0] O_DOUT,
  input wire logic O_DOUT_VALID,
  input wire logic O_PUSH_READY
);
  logic [6:0] take_reg;
  logic [7:0] age_reg;
  logic go_ok;
  assign go_ok = I_GO && (take_reg == 7'h00 || take_reg == 7'h40);
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      take_reg <= 7'h00;
    end else if (go_ok) begin
      take_reg <= 7'h01;
    end else if (take_reg != 7'h00 && take_reg != 7'h40) begin
      take_reg <= take_reg + 7'h01;
    end else begin
      take_reg <= 7'h00;
    end
  end
  // Age since first block; saturates so it never wraps
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      age_reg <= 8'h00;
    end else if ((go_ok || age_reg != 8'h00) && age_reg != 8'hFF) begin
      age_reg <= age_reg + 8'h01;
    end
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  sequence s_inv_take;
    go_ok && I_SEL != dctp_pkg::SEL_DCT && I_SEL != dctp_pkg::SEL_DCT_SUB;
  endsequence
  sequence s_clip_take;
    go_ok && (I_SEL == dctp_pkg::SEL_IDCT_CLIP || I_SEL == dctp_pkg::SEL_IDCT_ADD);
  endsequence
  a_reset_idle: assert property ($fell(I_RST) |-> !O_DOUT_VALID && O_PUSH_READY && O_DOUT == 12'h000)
    else $error("outputs not idle after reset");
  a_first_out: assert property (age_reg < 8'h81 |-> !O_DOUT_VALID)
    else $error("output before latency");
  a_out_latency: assert property (go_ok ##128 O_PUSH_READY |-> ##1 O_DOUT_VALID)
    else $error("first output late");
  a_inv_low: assert property (s_inv_take |-> ##129 (!O_DOUT_VALID || O_DOUT[2:0] == 3'h0) [*8])
    else $error("inverse low bits not zero");
  a_clip_sign: assert property (s_clip_take |-> ##129 (!O_DOUT_VALID || !O_DOUT[11]) [*8])
    else $error("clipped output negative");
  a_stall_hold: assert property (O_DOUT_VALID && !I_DOUT_READY |=> O_DOUT_VALID && $stable(O_DOUT))
    else $error("output changed while stalled");
  a_full_valid: assert property (!O_PUSH_READY |-> O_DOUT_VALID)
    else $error("full queue without valid");
  a_push_back: assert property (O_DOUT_VALID && I_DOUT_READY && !O_PUSH_READY |-> ##[1:2] O_PUSH_READY)
    else $error("queue stays full after pop");
endmodule : dctp_checker

bind dctp_datapath dctp_checker u_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_GO(I_GO), .I_SEL(I_SEL),
  .I_DIN(I_DIN), .I_AUX_OPERAND_IN(I_AUX_OPERAND_IN), .I_DOUT_READY(I_DOUT_READY), .O_DOUT(O_DOUT),
  .O_DOUT_VALID(O_DOUT_VALID), .O_PUSH_READY(O_PUSH_READY));

/* dctp_sink.sv */
// Purpose: downstream consumer collecting output words
// Assumes: stall command from the bench
// Notes: ready is the stall input inverted, with no register
`timescale 1ns/100ps

module dctp_sink (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [11:0] i_data,
  output logic o_ready
);
  logic [11:0] words [64];
  int cnt;
  assign o_ready = !i_stall;
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      cnt <= 0;
    end else if (i_valid && o_ready && cnt < 64) begin
      words[cnt] <= i_data;
      cnt <= cnt + 1;
    end
  end
endmodule : dctp_sink

/* tb.sv */
// Purpose: self-checking bench for the transform datapath
// Assumes: output sink model on the far side
// Notes: first three blocks are warm-up and unchecked
`timescale 1ns/100ps

module tb;
  logic clk;
  logic rst;
  logic go;
  logic [2:0] sel;
  logic [11:0] din;
  logic [8:0] aux;
  logic stall;
  logic clr;
  logic rdy;
  logic [11:0] dout;
  logic dval;
  logic pready;
  int error_cnt;
  int tests_run;
  logic [11:0] din_a [64];
  logic [8:0] aux_a [64];
  logic [11:0] exp_a [64];
  int c0 [8] = '{4096, 5681, 5352, 4816, 4096, 3218, 2217, 1130};
  dctp_datapath u_dut (.I_REF_CLK(clk), .I_RST(rst), .I_GO(go), .I_SEL(sel), .I_DIN(din),
    .I_AUX_OPERAND_IN(aux), .I_DOUT_READY(rdy), .O_DOUT(dout), .O_DOUT_VALID(dval), .O_PUSH_READY(pready));
  dctp_sink u_sink (.i_clk(clk), .i_clr(clr), .i_stall(stall), .i_valid(dval), .i_data(dout), .o_ready(rdy));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] want, input string msg);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s seen %h want %h", $time, msg, seen, want);
    end
  endtask : check
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  // Select is held at the plain inverse after the start edge so ignoring it is exercised
  task automatic run_blk(input logic [2:0] s, input logic add_m, input logic glitch, input logic hold);
    for (int t = 0; t < 212; t++) begin
      @(posedge clk);
      #2;
      go = (t == 0) || (glitch && t == 10);
      sel = (t == 0) ? s : dctp_pkg::SEL_IDCT;
      clr = (t == 0);
      stall = hold && t < 195;
      din = (t < 64) ? din_a[t] : 12'h000;
      if (add_m) aux = (t >= 124 && t < 188) ? aux_a[t - 124] : 9'h000;
      else aux = (t < 64) ? aux_a[t] : 9'h000;
      if (hold && t == 190) check({11'h000, pready}, 12'h000, "queue full");
    end
  endtask : run_blk
  task automatic cmp_blk(input int n, input string msg);
    check(12'(u_sink.cnt), 12'(n), msg);
    for (int i = 0; i < n; i++) check(u_sink.words[i], exp_a[i], msg);
  endtask : cmp_blk
  // First column constant, rest zero: only the first output row is nonzero
  task automatic sc_dct(input logic [2:0] s, input int d, input int a, input logic glitch);
    int v;
    v = (s == dctp_pkg::SEL_DCT_SUB) ? d - a : d;
    v = (v > 255) ? 255 : (v < -256) ? -256 : v;
    for (int i = 0; i < 64; i++) begin
      din_a[i] = (i < 8) ? {9'(d), 3'h7} : 12'h007;
      aux_a[i] = (i < 8) ? 9'(a) : 9'h000;
      exp_a[i] = (i < 8) ? 12'((c0[i] * v * 128 + 262144) >>> 19) : 12'h000;
    end
    run_blk(s, 1'b0, glitch, 1'b0);
    cmp_blk(64, "dct");
  endtask : sc_dct
  // Lone DC input spreads evenly over all 64 outputs
  task automatic sc_idct(input logic [2:0] s, input int x, input int a, input logic hold);
    int v;
    int w;
    v = (x * 65536 + 262144) >>> 19;
    v = (v > 255) ? 255 : v;
    for (int i = 0; i < 64; i++) begin
      din_a[i] = (i == 0) ? 12'(x) : 12'h000;
      aux_a[i] = 9'(a + i);
      w = (s == dctp_pkg::SEL_IDCT_ADD) ? v + a + i : v;
      w = (w > 255) ? 255 : (w < -256) ? -256 : w;
      if ((s == dctp_pkg::SEL_IDCT_CLIP || s == dctp_pkg::SEL_IDCT_ADD) && w < 0) w = 0;
      exp_a[i] = {9'(w), 3'h0};
    end
    run_blk(s, s == dctp_pkg::SEL_IDCT_ADD, 1'b0, hold);
    cmp_blk(hold ? 4 : 64, "idct");
  endtask : sc_idct
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    go = 1'b0;
    sel = 3'h0;
    din = 12'h000;
    aux = 9'h000;
    stall = 1'b0;
    clr = 1'b0;
    for (int i = 0; i < 64; i++) begin
      din_a[i] = 12'h000;
      aux_a[i] = 9'h000;
    end
    repeat (3) @(posedge clk);
    #2;
    rst = 1'b0;
    repeat (3) run_blk(dctp_pkg::SEL_DCT, 1'b0, 1'b0, 1'b0);
    sc_dct(dctp_pkg::SEL_DCT, 255, 100, 1'b0);
    sc_dct(dctp_pkg::SEL_DCT, -256, 0, 1'b1);
    sc_dct(dctp_pkg::SEL_DCT_SUB, -256, 255, 1'b0);
    sc_dct(dctp_pkg::SEL_DCT_SUB, 255, -256, 1'b0);
    sc_dct(dctp_pkg::SEL_DCT_SUB, 100, 30, 1'b1);
    sc_idct(dctp_pkg::SEL_IDCT, 4, 0, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT, -4, 0, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT, 3, 0, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT, -2048, 0, 1'b0);
    sc_idct(3'h2, -2048, 0, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT, 2047, 0, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT_CLIP, -2048, 0, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT_CLIP, 8, 0, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT_ADD, 8, -32, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT_ADD, 2047, 100, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT_ADD, -2048, 100, 1'b0);
    sc_idct(dctp_pkg::SEL_IDCT, 8, 0, 1'b1);
    give_verdict();
  end
  // About 4000 cycles expected; five times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule : tb
